// file: design/cshm_pkg.sv
// Constants for the CPU to serial sub-CPU handshake mailbox
package cshm_pkg;

  // ----------------------------------------------------------------
  // I/O addresses seen by the main CPU
  // ----------------------------------------------------------------
  localparam logic [7:0] HANDSHAKE_COMMAND_OFS      = 8'h01;
  localparam logic [7:0] HANDSHAKE_STATUS_OFS       = 8'h05;
  localparam logic [7:0] SERIAL_PARALLEL_BUFFER_OFS = 8'h06;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_RELEASE_BIT_A = 1;
  localparam int CMD_RELEASE_BIT_B = 0;
  localparam int STAT_READY_BIT_A  = 2;
  localparam int STAT_READY_BIT_B  = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       READY_RESET      = 1'b1;
  localparam logic       SUPPLY_RESET     = 1'b1;
  localparam logic       INHIBIT_RESET    = 1'b0;
  localparam logic [7:0] BUFFER_RESET     = 8'h00;
  localparam logic [7:0] READ_IDLE        = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int HOLD_MS       = 100;
  localparam int HOLD_CYCLES   = HOLD_MS * (CLK_HZ / 1000);
  localparam int SHIFT_BITS    = 8;
  localparam int FIFO_DEPTH    = 4;

endpackage

// file: design/cshm_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
module cshm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad
    $error("cshm_fifo: WIDTH >= 1 and DEPTH a power of two >= 2");
  end

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_q  <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// file: design/cshm_link_shifter.sv
// Shift clock side of the shared register, clocked by the sub-CPU
module cshm_link_shifter (
  input  wire logic       sck,
  input  wire logic       reset,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sdi,
  output logic            sdo,
  output logic      [7:0] rx_byte,
  output logic            done_tgl
);

  // ----------------------------------------------------------------
  // Bit counter and shifter
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] rx_q;
  logic       tgl_q;

  wire last_bit = (bit_cnt_q == 3'h7);

  // MSB first; byte comes from the shared buffer, which the FIFO drain loads while the sub-CPU owns it
  assign sdo      = tx_byte[~bit_cnt_q];
  assign rx_byte  = rx_q;
  assign done_tgl = tgl_q;

  // Result is published only after the eighth edge, so the clock may stop
  always_ff @(posedge sck or posedge reset)
  begin
    if (reset)
    begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
      rx_q      <= 8'h00;
      tgl_q     <= 1'b0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[6:0], sdi};
      rx_q      <= last_bit ? {shift_q[6:0], sdi} : rx_q;
      tgl_q     <= last_bit ? ~tgl_q : tgl_q;
    end
  end

endmodule

// file: design/cshm_top.sv
// Handshake mailbox between the main CPU bus and the serial sub-CPU
module cshm_top #(
  parameter int unsigned HOLD_CYCLES = cshm_pkg::HOLD_CYCLES,
  parameter int          FIFO_DEPTH  = cshm_pkg::FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_rd,
  input  wire logic       io_wr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic       sub_sck,
  input  wire logic       sub_sdi,
  output logic            sub_sdo,
  input  wire logic       sub_ack,
  output logic            sub_cmd_waiting,
  output logic            shift_accept,
  input  wire logic       supply_request,
  output logic            serial_supply_switch,
  output logic            transmit_inhibit
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Wide enough for the full settle time at 40 MHz
  localparam int TW = 22;

  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << TW))
  begin : g_bad_hold
    $error("cshm_top: HOLD_CYCLES out of range");
  end

  // Pointer wrap in the FIFO needs a power of two
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("cshm_top: FIFO_DEPTH must be a power of two >= 2");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  function automatic logic rose(input logic cur, input logic prev);
    rose = cur && !prev;
  endfunction

  // Ready shows on both status bit positions
  function automatic logic [7:0] status_of(input logic ready);
    status_of                             = 8'h00;
    status_of[cshm_pkg::STAT_READY_BIT_A] = ready;
    status_of[cshm_pkg::STAT_READY_BIT_B] = ready;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]    shared_shift_buffer_q;
  logic [7:0]    shared_shift_buffer_d;
  logic          owner_ready_flipflop_q;
  logic          owner_ready_flipflop_d;
  logic [7:0]    rdata_q;
  logic [7:0]    rdata_d;
  logic          cmd_waiting_q;
  logic          accept_q;

  logic          ack_meta_q;
  logic          ack_sync_q;
  logic          ack_prev_q;
  logic          tgl_meta_q;
  logic          tgl_sync_q;
  logic          tgl_prev_q;
  logic          sup_meta_q;
  logic          sup_sync_q;

  logic          switch_q;
  logic          inhibit_q;
  logic [TW-1:0] hold_cnt_q;
  logic [TW-1:0] hold_cnt_d;

  // Gray along off, settle on, on, settle off
  typedef enum logic [1:0] {
    SUP_OFF        = 2'b00,
    SUP_SETTLE_ON  = 2'b01,
    SUP_ON         = 2'b11,
    SUP_SETTLE_OFF = 2'b10
  } cshm_sup_state_t;
  cshm_sup_state_t sup_state_q;
  cshm_sup_state_t sup_state_d;

  logic          link_sdo;
  logic [7:0]    link_rx_byte;
  logic          link_done_tgl;

  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [7:0]    fifo_out_data;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire hit_cmd    = addr_hit(io_addr, cshm_pkg::HANDSHAKE_COMMAND_OFS);
  wire hit_status = addr_hit(io_addr, cshm_pkg::HANDSHAKE_STATUS_OFS);
  wire hit_buffer = addr_hit(io_addr, cshm_pkg::SERIAL_PARALLEL_BUFFER_OFS);

  // Either release bit position is accepted
  wire release_bits = io_wdata[cshm_pkg::CMD_RELEASE_BIT_A]
                    | io_wdata[cshm_pkg::CMD_RELEASE_BIT_B];
  wire cmd_release  = io_wr && hit_cmd && release_bits;

  // Main side may touch the buffer only while it owns it
  wire main_buf_wr  = io_wr && hit_buffer && owner_ready_flipflop_q;

  wire ack_rise     = rose(ack_sync_q, ack_prev_q);
  wire byte_arrived = tgl_sync_q ^ tgl_prev_q;

  // Drain stalls while the main CPU owns the buffer, so the FIFO can fill
  wire fifo_take    = !owner_ready_flipflop_q;
  wire fifo_drain   = fifo_out_valid && fifo_take;

  // ----------------------------------------------------------------
  // Ownership flag
  // ----------------------------------------------------------------
  // Acknowledge wins over a command release in the same cycle
  assign owner_ready_flipflop_d = ack_rise    ? 1'b1
                                : cmd_release ? 1'b0
                                : owner_ready_flipflop_q;

  // ----------------------------------------------------------------
  // Shared buffer
  // ----------------------------------------------------------------
  assign shared_shift_buffer_d = main_buf_wr ? io_wdata
                               : fifo_drain  ? fifo_out_data
                               : shared_shift_buffer_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] status_word = status_of(owner_ready_flipflop_q);

  wire [7:0] buffer_view = owner_ready_flipflop_q ? shared_shift_buffer_q
                         : cshm_pkg::READ_IDLE;

  assign rdata_d = !io_rd     ? rdata_q
                 : hit_status ? status_word
                 : hit_buffer ? buffer_view
                 : cshm_pkg::READ_IDLE;

  // ----------------------------------------------------------------
  // Main domain registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      owner_ready_flipflop_q <= cshm_pkg::READY_RESET;
      cmd_waiting_q          <= 1'b0;
      shared_shift_buffer_q  <= cshm_pkg::BUFFER_RESET;
      rdata_q                <= cshm_pkg::READ_IDLE;
      accept_q               <= 1'b0;
    end
    else
    begin
      owner_ready_flipflop_q <= owner_ready_flipflop_d;
      cmd_waiting_q          <= !owner_ready_flipflop_d;
      shared_shift_buffer_q  <= shared_shift_buffer_d;
      rdata_q                <= rdata_d;
      accept_q               <= fifo_in_ready;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers for pins and the link toggle
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
      ack_prev_q <= 1'b0;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_prev_q <= 1'b0;
      sup_meta_q <= cshm_pkg::SUPPLY_RESET;
      sup_sync_q <= cshm_pkg::SUPPLY_RESET;
    end
    else
    begin
      ack_meta_q <= sub_ack;
      ack_sync_q <= ack_meta_q;
      ack_prev_q <= ack_sync_q;
      tgl_meta_q <= link_done_tgl;
      tgl_sync_q <= tgl_meta_q;
      tgl_prev_q <= tgl_sync_q;
      sup_meta_q <= supply_request;
      sup_sync_q <= sup_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Serial supply sequencing
  // ----------------------------------------------------------------
  // Any change of the switch restarts the settle time with inhibit low
  wire supply_change = (sup_sync_q != switch_q);
  wire hold_done     = (hold_cnt_q == '0);

  assign hold_cnt_d = supply_change ? TW'(HOLD_CYCLES - 1)
                    : hold_done     ? hold_cnt_q
                    : hold_cnt_q - 1'b1;

  // Inhibit rises only out of the settle state, never straight from off
  always_comb
  begin
    sup_state_d = sup_state_q;
    case (sup_state_q)
      SUP_OFF:
      begin
        if (supply_change)
        begin
          sup_state_d = SUP_SETTLE_ON;
        end
      end
      SUP_SETTLE_ON:
      begin
        if (supply_change)
        begin
          sup_state_d = SUP_SETTLE_OFF;
        end
        else if (hold_done)
        begin
          sup_state_d = SUP_ON;
        end
      end
      SUP_ON:
      begin
        if (supply_change)
        begin
          sup_state_d = SUP_SETTLE_OFF;
        end
      end
      SUP_SETTLE_OFF:
      begin
        if (supply_change)
        begin
          sup_state_d = SUP_SETTLE_ON;
        end
        else if (hold_done)
        begin
          sup_state_d = SUP_OFF;
        end
      end
      // Unused codes fall back to supply off
      default:
      begin
        sup_state_d = SUP_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      switch_q    <= cshm_pkg::SUPPLY_RESET;
      inhibit_q   <= cshm_pkg::INHIBIT_RESET;
      hold_cnt_q  <= TW'(HOLD_CYCLES - 1);
      sup_state_q <= cshm_pkg::SUPPLY_RESET ? SUP_SETTLE_ON : SUP_OFF;
    end
    else
    begin
      switch_q    <= sup_sync_q;
      // Held low through the settle time after on and after off
      inhibit_q   <= (sup_state_d == SUP_ON);
      hold_cnt_q  <= hold_cnt_d;
      sup_state_q <= sup_state_d;
    end
  end

  // ----------------------------------------------------------------
  // Received byte queue
  // ----------------------------------------------------------------
  // Link byte stays put for seven more shift clocks, far past the sync delay
  cshm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (byte_arrived),
    .in_ready  (fifo_in_ready),
    .in_data   (link_rx_byte),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Shift clock domain
  // ----------------------------------------------------------------
  cshm_link_shifter u_link (
    .sck      (sub_sck),
    .reset    (reset),
    .tx_byte  (shared_shift_buffer_q),
    .sdi      (sub_sdi),
    .sdo      (link_sdo),
    .rx_byte  (link_rx_byte),
    .done_tgl (link_done_tgl)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_rdata             = rdata_q;
  assign sub_cmd_waiting      = cmd_waiting_q;
  assign shift_accept         = accept_q;
  // Not from a flop: bit seven must stand before the first shift edge
  assign sub_sdo              = link_sdo;
  assign serial_supply_switch = switch_q;
  assign transmit_inhibit     = inhibit_q;

endmodule

// file: tb/cshm_sva.sv
// Port checker for the handshake mailbox top
module cshm_sva #(
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] io_addr,
  input wire logic       io_rd,
  input wire logic       io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       sub_ack,
  input wire logic       sub_cmd_waiting,
  input wire logic       shift_accept,
  input wire logic       serial_supply_switch,
  input wire logic       transmit_inhibit
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Helper: cycles since the supply switch went on
  // ----------------------------------------------------------------
  int unsigned on_cnt_q;
  always_ff @(posedge clock or posedge reset)
    if (reset)
      on_cnt_q <= 0;
    else if (!serial_supply_switch)
      on_cnt_q <= 0;
    else if (on_cnt_q < 1000)
      on_cnt_q <= on_cnt_q + 1;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_state: assert property ($fell(reset) |->
    serial_supply_switch && !transmit_inhibit && !sub_cmd_waiting ##1 shift_accept)
    else $error("outputs wrong after reset");
  a_cmd_alert: assert property (
    io_wr && io_addr == 8'h01 && (io_wdata[1] || io_wdata[0]) |-> ##2 sub_cmd_waiting)
    else $error("command write did not alert sub side");
  a_ack_ready: assert property ($rose(sub_ack) |-> ##[3:8] !sub_cmd_waiting)
    else $error("acknowledge did not return ownership");
  a_status_bits: assert property (io_rd && io_addr == 8'h05 |=>
    io_rdata[2] == io_rdata[0] && io_rdata[2] == !$past(sub_cmd_waiting))
    else $error("status bits disagree with alert line");
  a_foreign_read: assert property (
    io_rd && io_addr == 8'h06 && sub_cmd_waiting && !sub_ack |=> io_rdata == 8'h00)
    else $error("buffer readable while not owned");
  a_unmapped_read: assert property (
    io_rd && io_addr != 8'h05 && io_addr != 8'h06 |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  a_inhibit_hold: assert property ($rose(transmit_inhibit) |->
    on_cnt_q + 3 >= HOLD_CYCLES && on_cnt_q <= HOLD_CYCLES + 4)
    else $error("inhibit rose at wrong time");
  a_inhibit_late: assert property (on_cnt_q == HOLD_CYCLES + 5 |-> transmit_inhibit)
    else $error("inhibit never rose");
  a_off_inhibit: assert property (
    !serial_supply_switch && !$fell(serial_supply_switch) |-> !transmit_inhibit)
    else $error("inhibit high with supply off");

  c_cmd_sent: cover property ($rose(sub_cmd_waiting));
  c_inhibit_on: cover property ($rose(transmit_inhibit));
  c_supply_off: cover property ($fell(serial_supply_switch));
endmodule

bind cshm_top cshm_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_cshm_sva (
  .clock(clock), .reset(reset), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .sub_ack(sub_ack),
  .sub_cmd_waiting(sub_cmd_waiting), .shift_accept(shift_accept),
  .serial_supply_switch(serial_supply_switch), .transmit_inhibit(transmit_inhibit));

// file: tb/cshm_sub_model.sv
// Sub-CPU partner: waits for the alert, shifts bytes, acknowledges
module cshm_sub_model (
  input  wire logic       sub_sdo,
  input  wire logic       sub_cmd_waiting,
  input  wire logic       slow,
  output logic            sub_sck,
  output logic            sub_sdi,
  output logic            sub_ack,
  output logic      [7:0] got_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk;

  // ----------------------------------------------------------------
  // One byte, MSB first; clock stands still outside frames
  // ----------------------------------------------------------------
  task automatic shift8(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sub_sdi = tx[i];
      #80;
      rx[i] = sub_sdo;
      sub_sck = 1'b1;
      #80;
      sub_sck = 1'b0;
    end
    // Released line must not keep the last bit
    sub_sdi = ~tx[0];
  endtask

  initial
  begin
    sub_sck = 1'b0;
    sub_sdi = 1'b1;
    sub_ack = 1'b0;
    got_cmd = 8'h00;
    #37;
    forever
    begin
      wait (sub_cmd_waiting === 1'b1);
      #(slow ? 2000 : 200);
      shift8(8'hff, got_cmd);
      // Select, start and read of the converter stay inside
      // Channel in the low bits picks the source
      shift8({got_cmd[1:0], got_cmd[7:2] ^ 6'h2a}, junk);
      #1000;
      sub_ack = 1'b1;
      wait (sub_cmd_waiting === 1'b0);
      sub_ack = 1'b0;
    end
  end
endmodule

// file: tb/cshm_top_bench.sv
// Self-checking bench for the handshake mailbox
module cshm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] io_addr, io_wdata, io_rdata, got_cmd, v, cmd;
  logic       io_rd, io_wr, sub_sck, sub_sdi, sub_sdo, sub_ack, sub_cmd_waiting;
  logic       shift_accept, supply_request, serial_supply_switch, transmit_inhibit, slow;
  logic [31:0] seed = 32'h0000004d;
  logic [31:0] tmp;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  logic [7:0]  exp_q[$];

  always #12.5 clock = ~clock;

  cshm_top #(.HOLD_CYCLES(HOLD), .FIFO_DEPTH(4)) dut (
    .clock(clock), .reset(reset), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .sub_sck(sub_sck), .sub_sdi(sub_sdi),
    .sub_sdo(sub_sdo), .sub_ack(sub_ack), .sub_cmd_waiting(sub_cmd_waiting),
    .shift_accept(shift_accept), .supply_request(supply_request),
    .serial_supply_switch(serial_supply_switch), .transmit_inhibit(transmit_inhibit));

  cshm_sub_model sub (
    .sub_sdo(sub_sdo), .sub_cmd_waiting(sub_cmd_waiting), .slow(slow),
    .sub_sck(sub_sck), .sub_sdi(sub_sdi), .sub_ack(sub_ack), .got_cmd(got_cmd));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // Bus tasks enter and leave at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    // Idle cycle so a following strobe is not reassigned at once
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    d = io_rdata;
    @(negedge clock);
  endtask

  task automatic wait_ready();
    n = 0;
    do
      rd(8'h05, v);
    while (v[2] !== 1'b1 && ++n < 600);
    check("ready poll", 8'h05, v);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    supply_request = 1'b1;
    slow = 1'b0;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    check("switch", 8'h01, {7'h00, serial_supply_switch});
    check("inhibit", 8'h00, {7'h00, transmit_inhibit});
    rd(8'h05, v);
    check("status", 8'h05, v);
    check("accept", 8'h01, {7'h00, shift_accept});
    rd(8'h07, v);
    check("unmapped", 8'h00, v);
    wr(8'h07, 8'h5a);
    rd(8'h06, v);
    check("buffer", cshm_pkg::BUFFER_RESET, v);
    repeat (HOLD + 10) @(negedge clock);
    check("inhibit on", 8'h01, {7'h00, transmit_inhibit});
    for (int i = 0; i < 4; i++)
    begin
      tmp = rnd();
      cmd = {tmp[7:2], 2'(i)};
      slow = tmp[8];
      exp_q.push_back({cmd[1:0], cmd[7:2] ^ 6'h2a});
      wait_ready();
      wr(8'h06, cmd);
      rd(8'h06, v);
      check("buffer", cmd, v);
      wr(8'h01, i[0] ? 8'h01 : 8'h02);
      @(negedge clock);
      rd(8'h05, v);
      check("status busy", 8'h00, v);
      wr(8'h06, ~cmd);
      rd(8'h06, v);
      check("foreign read", 8'h00, v);
      wait_ready();
      check("cmd seen", cmd, got_cmd);
      rd(8'h06, v);
      check("result", exp_q.pop_front(), v);
    end
    supply_request = 1'b0;
    repeat (6) @(negedge clock);
    check("switch off", 8'h00, {7'h00, serial_supply_switch});
    repeat (HOLD + 10) @(negedge clock);
    check("inhibit off", 8'h00, {7'h00, transmit_inhibit});
    supply_request = 1'b1;
    repeat (6) @(negedge clock);
    check("inhibit early", 8'h00, {7'h00, transmit_inhibit});
    repeat (HOLD + 10) @(negedge clock);
    check("inhibit again", 8'h01, {7'h00, transmit_inhibit});
    wrap_up();
  end
endmodule
